// ===== logic/rlb_pkg.sv
// Package: register map, field layout and sequencing constants for the loopback requester
`default_nettype none
package rlb_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL   = 6'h07;
  localparam logic [5:0] IDX_MODE      = 6'h08;
  localparam logic [5:0] IDX_INV_VEC   = 6'h20;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int        BIT_GO        = 7;
  localparam int        BIT_CONNECT   = 6;
  localparam int        BIT_METHOD    = 5;
  localparam int        CH_MSB        = 4;
  localparam int        DS2_LSB       = 2;
  localparam int        MODE_CBIT     = 0;
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [3:0] INV_VEC_RST   = 4'h0;
  localparam logic       MODE_RST      = 1'b0;
  // ----------------------------------------------------------------
  // FEAC codewords, one bit per DS3 frame
  // ----------------------------------------------------------------
  localparam int        WORD_BITS     = 16;
  localparam int        WORDS_HALF    = 10;
  localparam int        TOTAL_FRAMES  = 2 * WORDS_HALF * WORD_BITS;
  localparam logic [5:0] ACTIVATE_CODE = 6'h07;
  localparam logic [8:0] FLAG_TAIL     = 9'h0ff;
  typedef enum logic [1:0] {RLB_IDLE, RLB_FIRST, RLB_SECOND, RLB_INVERT} rlb_state_e;
endpackage
`default_nettype wire

// ===== logic/rlb_frame_counter.sv
// Frame counter that paces a loopback request in DS3 frames
`default_nettype none
module rlb_frame_counter #(
  parameter int LIMIT = 320,
  parameter int W     = 9
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         step,
  output logic [W-1:0]      count,
  output logic              last
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign last       = (count_reg == W'(LIMIT - 1));
  assign count_next = clear ? '0 : (step ? (last ? '0 : count_reg + W'(1)) : count_reg);
  assign count      = count_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// ===== logic/rlb_top.sv
// Remote loopback request generator with classic Wishbone register port
//
// Added by the designer: the Wishbone register port.
`default_nettype none
module rlb_top #(
  parameter logic [5:0] DEACTIVATE_CODE = 6'h1c
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frame_pulse,
  output logic             feac_bit,
  output logic             feac_active,
  output logic             inv_active,
  output logic [3:0]       inversion_vector_bits,
  output logic             connect_select
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rlb_pkg::rlb_state_e state_reg;
  rlb_pkg::rlb_state_e state_next;
  logic [6:0]  ctrl_reg;
  logic [3:0]  invvec_reg;
  logic        mode_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        feac_bit_reg;
  logic        feac_act_reg;
  logic        inv_act_reg;
  logic [8:0]  frame_cnt;
  logic        frame_last;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [5:0] idx      = wb_adr_i[7:2];
  wire logic       req      = wb_cyc_i & wb_stb_i;
  wire logic       wr_fire  = req & wb_we_i & ack_reg & wb_sel_i[0];
  wire logic       hit_ctrl = (idx == rlb_pkg::IDX_CONTROL);
  wire logic       hit_mode = (idx == rlb_pkg::IDX_MODE);
  wire logic       hit_inv  = (idx == rlb_pkg::IDX_INV_VEC);
  wire logic       busy     = (state_reg != rlb_pkg::RLB_IDLE);
  wire logic [7:0] wbyte    = wb_dat_i[7:0];

  // Ds2 field zero names the whole DS3; M13 framing cannot carry that
  wire logic       ds3_req  = (wbyte[rlb_pkg::CH_MSB:rlb_pkg::DS2_LSB] == 3'h0);
  wire logic       allowed  = mode_reg | ~ds3_req;
  // Writes during a running request are dropped whole
  wire logic       ctrl_wr  = wr_fire & hit_ctrl & ~busy;
  wire logic       start    = ctrl_wr & wbyte[rlb_pkg::BIT_GO] & allowed;
  // M13 framing has no FEAC channel, so inversions are forced there
  wire logic       use_feac = mode_reg & ~wbyte[rlb_pkg::BIT_METHOD];

  wire logic [31:0] rd_data =
    hit_ctrl ? {24'h000000, busy, ctrl_reg} :
    hit_mode ? {31'h00000000, mode_reg} :
    hit_inv  ? {28'h0000000, invvec_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // Codeword building
  // ----------------------------------------------------------------
  // Translated six-bit code from the five channel bits
  function automatic logic [5:0] chan_code(input logic [4:0] ch);
    chan_code = {1'b1, ch};
  endfunction

  function automatic logic [15:0] feac_word(input logic [5:0] code);
    feac_word = {1'b0, code, 1'b0, rlb_pkg::FLAG_TAIL[7:0]};
  endfunction

  wire logic [5:0]  first_code = ctrl_reg[rlb_pkg::BIT_CONNECT] ?
                                 rlb_pkg::ACTIVATE_CODE : DEACTIVATE_CODE;
  wire logic [15:0] word_first = feac_word(first_code);
  wire logic [15:0] word_chan  = feac_word(chan_code(ctrl_reg[4:0]));
  wire logic [15:0] cur_word   = (state_reg == rlb_pkg::RLB_FIRST) ? word_first : word_chan;
  wire logic [3:0]  bit_idx    = 4'hf - frame_cnt[3:0];
  wire logic        cur_bit    = cur_word[bit_idx];
  wire logic        half_end   = (frame_cnt == 9'(rlb_pkg::TOTAL_FRAMES / 2 - 1));
  wire logic        step       = busy & frame_pulse;

  rlb_frame_counter #(
    .LIMIT (rlb_pkg::TOTAL_FRAMES),
    .W     (9)
  ) u_cnt (
    .clk    (clk),
    .resetn (resetn),
    .clear  (start),
    .step   (step),
    .count  (frame_cnt),
    .last   (frame_last)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rlb_pkg::RLB_IDLE: begin
        if (start) begin
          state_next = use_feac ? rlb_pkg::RLB_FIRST : rlb_pkg::RLB_INVERT;
        end
      end
      rlb_pkg::RLB_FIRST: begin
        if (step && half_end) begin
          state_next = rlb_pkg::RLB_SECOND;
        end
      end
      rlb_pkg::RLB_SECOND,
      rlb_pkg::RLB_INVERT: begin
        if (step && frame_last) begin
          state_next = rlb_pkg::RLB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= rlb_pkg::RLB_IDLE;
      ctrl_reg     <= rlb_pkg::CONTROL_RST[6:0];
      invvec_reg   <= rlb_pkg::INV_VEC_RST;
      mode_reg     <= rlb_pkg::MODE_RST;
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h00000000;
      feac_bit_reg <= 1'b1;
      feac_act_reg <= 1'b0;
      inv_act_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= req & ~ack_reg;
      dat_reg   <= rd_data;
      if (ctrl_wr) begin
        ctrl_reg <= wbyte[6:0];
      end
      if (wr_fire && hit_mode && !busy) begin
        mode_reg <= wbyte[rlb_pkg::MODE_CBIT];
      end
      if (wr_fire && hit_inv && !busy) begin
        invvec_reg <= wbyte[3:0];
      end
      if (step && (state_reg == rlb_pkg::RLB_FIRST || state_reg == rlb_pkg::RLB_SECOND)) begin
        feac_bit_reg <= cur_bit;
      end else if (!feac_act_reg) begin
        feac_bit_reg <= 1'b1;
      end
      feac_act_reg <= (state_next == rlb_pkg::RLB_FIRST) ||
                      (state_next == rlb_pkg::RLB_SECOND);
      inv_act_reg  <= (state_next == rlb_pkg::RLB_INVERT);
    end
  end

  assign wb_ack_o              = ack_reg;
  assign wb_dat_o              = dat_reg;
  assign feac_bit              = feac_bit_reg;
  assign feac_active           = feac_act_reg;
  assign inv_active            = inv_act_reg;
  assign inversion_vector_bits = invvec_reg;
  assign connect_select        = ctrl_reg[rlb_pkg::BIT_CONNECT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [9:0] busy_frames;
  always_ff @(posedge clk) begin
    if (!resetn || start) begin
      busy_frames <= 10'h000;
    end else if (step) begin
      busy_frames <= busy_frames + 10'h001;
    end
  end

  chk_go_starts: assert property (start |=> busy)
    else $error("go write did not start request");
  chk_busy_readback: assert property (ack_reg && !$past(ack_reg) && $past(hit_ctrl) |->
    dat_reg[7] == $past(busy))
    else $error("execute bit readback wrong");
  chk_m13_no_ds3: assert property (ctrl_wr && !mode_reg && ds3_req |=> !busy)
    else $error("DS3 request started in M13 mode");
  chk_m13_no_feac: assert property (start && !mode_reg |=> state_reg == rlb_pkg::RLB_INVERT)
    else $error("FEAC used in M13 mode");
  chk_first_half: assert property (step && state_reg == rlb_pkg::RLB_SECOND |->
    busy_frames >= 10'd160)
    else $error("channel words began early");
  chk_end_count: assert property (busy && !$past(start) ##1 !busy |->
    $past(busy_frames) == 10'd319 && $past(step))
    else $error("request did not last 320 frames");
  chk_no_restart: assert property (busy && wr_fire && hit_ctrl |=> $stable(ctrl_reg))
    else $error("control changed during request");
  chk_first_word: assert property (step && state_reg == rlb_pkg::RLB_FIRST |=>
    feac_bit == word_first[$past(bit_idx)])
    else $error("first word bit wrong");
  chk_chan_word: assert property (step && state_reg == rlb_pkg::RLB_SECOND |=>
    feac_bit == word_chan[$past(bit_idx)])
    else $error("channel word bit wrong");
  chk_ack_pulse: assert property (ack_reg |=> !ack_reg)
    else $error("ack longer than one cycle");

  cov_feac_connect: cover property (start && use_feac && wbyte[rlb_pkg::BIT_CONNECT]);
  cov_feac_disc: cover property (start && use_feac && !wbyte[rlb_pkg::BIT_CONNECT]);
  cov_invert: cover property (start && !use_feac);
  cov_done: cover property (busy ##1 !busy);
endmodule
`default_nettype wire

// ===== verif/rlb_far_end.sv
// Far-end terminal model: DS3 frame timing source and C3 bit collector
`default_nettype none
module rlb_far_end (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   busy,
  input  wire logic   feac_bit,
  output logic        frame_pulse,
  output logic [15:0] word,
  output logic [9:0]  bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg;
  logic       take_reg;
  logic       busy_reg;
  // ------------------------------------------------------------
  // Frame every four clocks keeps a request near 1280 cycles
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    div_reg     <= resetn ? div_reg + 2'h1 : 2'h0;
    frame_pulse <= resetn && (div_reg == 2'h3);
    take_reg    <= frame_pulse && busy;
    busy_reg    <= busy;
    if (!resetn || (busy && !busy_reg)) begin
      bits <= 10'h000;
      word <= 16'h0000;
    end else if (take_reg) begin
      bits <= bits + 10'h001;
      word <= {word[14:0], feac_bit};
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_rlb_top.sv
// Bench for the loopback requester: register tasks and request scenarios
`default_nettype none
module test_rlb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  wire  [31:0] dat_o;
  wire         ack, fp, fbit, fact, iact, conn;
  wire  [3:0]  vec;
  wire  [15:0] word;
  wire  [9:0]  bits;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  rlb_top dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .frame_pulse(fp), .feac_bit(fbit),
    .feac_active(fact), .inv_active(iact), .inversion_vector_bits(vec),
    .connect_select(conn));
  rlb_far_end far (.clk(clk), .resetn(resetn), .busy(fact | iact),
    .feac_bit(fbit), .frame_pulse(fp), .word(word), .bits(bits));
  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Held until ack is sampled; released for a cycle after
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic poll_idle();
    do wb(1'b0, 8'h1c, 8'h00); while (rdat[7] !== 1'b0);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    wb(1'b0, 8'h1c, 8'h00);
    check("control", 32'h0, rdat);
    check("idle bit", 32'h1, {31'h0, fbit});
    wb(1'b1, 8'hfc, 8'h5a);
    wb(1'b0, 8'hfc, 8'h00);
    check("unmapped", 32'h0, rdat);
    $display("test reset done");
  endtask
  task automatic t_feac(input logic [7:0] ctl, input logic [15:0] first,
                        input logic [15:0] chan);
    wb(1'b1, 8'h20, 8'h01);
    wb(1'b1, 8'h1c, ctl);
    wb(1'b0, 8'h1c, 8'h00);
    check("go busy", {24'h0, ctl}, rdat);
    wb(1'b1, 8'h1c, 8'h00);
    wb(1'b0, 8'h1c, 8'h00);
    check("busy write", {24'h0, ctl}, rdat);
    check("connect", {31'h0, ctl[6]}, {31'h0, conn});
    check("feac on", 32'h1, {31'h0, fact});
    while (bits !== 10'd160) @(negedge clk);
    check("first word", {16'h0, first}, {16'h0, word});
    poll_idle();
    check("frames", 32'd320, {22'h0, bits});
    check("chan word", {16'h0, chan}, {16'h0, word});
    check("feac off", 32'h0, {31'h0, fact});
    $display("test feac %h done", ctl);
  endtask
  task automatic t_invert();
    wb(1'b1, 8'h80, 8'h0a);
    wb(1'b0, 8'h80, 8'h00);
    check("vector reg", 32'h0a, rdat);
    check("vector out", 32'ha, {28'h0, vec});
    wb(1'b1, 8'h1c, 8'he5);
    @(negedge clk);
    check("inv on", 32'h1, {31'h0, iact});
    check("no feac", 32'h0, {31'h0, fact});
    poll_idle();
    check("inv off", 32'h0, {31'h0, iact});
    $display("test invert done");
  endtask
  task automatic t_m13();
    wb(1'b1, 8'h20, 8'h00);
    wb(1'b1, 8'h1c, 8'h83);
    wb(1'b0, 8'h1c, 8'h00);
    check("ds3 in m13", 32'h03, rdat);
    check("no start", 32'h0, {30'h0, fact, iact});
    wb(1'b1, 8'h1c, 8'h85);
    wb(1'b0, 8'h1c, 8'h00);
    check("m13 ds1 go", 32'h85, rdat);
    check("m13 invert", 32'h1, {30'h0, fact, iact});
    poll_idle();
    check("m13 done", 32'h0, {30'h0, fact, iact});
    $display("test m13 done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_feac(8'hce, 16'h0eff, 16'h5cff);
    t_feac(8'h9d, 16'h38ff, 16'h7aff);
    t_invert();
    t_m13();
    end_of_test();
  end
endmodule
`default_nettype wire
